// [hdl/adc_port_defs.vh]
// Constants for the pipelined converter output port.
// Assumes inclusion by the output port and the testbench only.
`ifndef ADC_PORT_DEFS_VH
`define ADC_PORT_DEFS_VH
`define ADC_DATA_W 10
`define ADC_STAGES 9
`define ADC_STAGE_BITS 2
`define ADC_LATENCY 5
`define ADC_PD_INVALID 5
`define ADC_FIFO_DEPTH 8
`define ADC_MIDSCALE 10'h200
`define ADC_CORR_OFFSET 10'h2FE
`define ADC_CODE_MAX 10'h3FF
`define ADC_CODE_MIN 10'h000
`endif

// [hdl/sample_fifo.v]
// Small synchronous FIFO holding converted sample words.
// Assumes one clock and a synchronous active-high reset.
module sample_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] count_r;
  reg out_valid_r;
  wire push;
  wire pop;
  wire load;

  assign o_in_ready = (count_r != DEPTH[AW:0]);
  assign push = i_in_valid && o_in_ready;
  // Output register refills when empty or being taken
  assign load = (count_r != {(AW+1){1'b0}}) && (!out_valid_r || i_out_ready);
  assign pop = load;
  assign o_out_valid = out_valid_r;

  always @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      out_valid_r <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
        o_out_data <= mem_r[rd_ptr_r];
        out_valid_r <= 1'b1;
      end else if (i_out_ready) begin
        out_valid_r <= 1'b0;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // sample_fifo

// [hdl/adc_output_port.v]
// Digital side of a 10-bit pipelined converter: stage alignment, error
// correction, latency, output enable and power-down gating of the data port.
// Assumes stage decisions arrive each cycle on i_stage_code, synchronous to
// i_core_clk, which stands for the convert clock.
`include "adc_port_defs.vh"
module adc_output_port #(
  parameter DATA_W = `ADC_DATA_W,
  parameter STAGES = `ADC_STAGES,
  parameter LATENCY = `ADC_LATENCY,
  parameter FIFO_DEPTH = `ADC_FIFO_DEPTH
) (
  input wire i_core_clk,
  input wire i_srst,
  input wire [2*STAGES-1:0] i_stage_code,
  input wire i_oe_n,
  input wire i_pwrdn,
  input wire i_rd_ready,
  output wire o_rd_valid,
  output wire [DATA_W-1:0] o_rd_data,
  output reg [DATA_W-1:0] o_sample,
  output wire [DATA_W-1:0] o_sample_oe,
  output reg o_sample_valid,
  output reg o_phase_sample,
  output reg o_phase_hold,
  output wire o_overflow
);
  // Stage k resolves in cycle k after sampling; delays align all to the last
  reg [2*STAGES-1:0] align_r [0:STAGES-1];
  reg [DATA_W-1:0] corr_r;
  reg [DATA_W-1:0] corr_nxt;
  reg [DATA_W+1:0] acc;
  reg [2*STAGES-1:0] aligned;
  reg [2:0] phase_r;
  reg [LATENCY-1:0] vld_pipe_r;
  reg overflow_r;
  wire fifo_in_ready;
  wire out_on;
  integer i;
  integer k;

  localparam PH_IDLE = 3'h0;
  localparam PH_SAMPLE = 3'h1;
  localparam PH_GAP1 = 3'h2;
  localparam PH_HOLD = 3'h3;

  // Clamp a raw corrected sum into the code range
  function [DATA_W-1:0] clamp_code;
    input [DATA_W+1:0] sum;
    begin
      if (sum[DATA_W+1]) begin
        clamp_code = `ADC_CODE_MIN;
      end else if (sum[DATA_W]) begin
        clamp_code = `ADC_CODE_MAX;
      end else begin
        clamp_code = sum[DATA_W-1:0];
      end
    end
  endfunction

  // Stage k's two bits are taken at cycle k; later stages wait less
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      for (i = 0; i < STAGES; i = i + 1) begin
        align_r[i] <= {(2*STAGES){1'b0}};
      end
    end else begin
      align_r[0] <= {{(2*STAGES-2){1'b0}}, i_stage_code[2*STAGES-1 -: 2]};
      for (i = 1; i < STAGES; i = i + 1) begin
        align_r[i] <= align_r[i-1] << 2;
        align_r[i][1:0] <= i_stage_code[2*(STAGES-1-i)+1 -: 2];
      end
    end
  end

  // Overlapping bits summed: each stage weight doubles, the redundant bit
  // of each stage overlaps the next, which absorbs comparator offsets.
  always @* begin
    aligned = align_r[STAGES-1];
    acc = {(DATA_W+2){1'b0}};
    for (k = 0; k < STAGES; k = k + 1) begin
      acc = acc + ({{DATA_W{1'b0}}, aligned[2*k+1 -: 2]} << k);
    end
    // Re-centre: the middle of the redundant sum range lands on midscale,
    // so all-zero decisions go negative and clamp to the bottom code
    acc = acc + {2'b00, `ADC_MIDSCALE} - {2'b00, `ADC_CORR_OFFSET};
    corr_nxt = clamp_code(acc);
  end

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      corr_r <= `ADC_MIDSCALE;
    end else begin
      corr_r <= corr_nxt;
    end
  end

  // Track/hold phases: one sample phase, a dead gap, then hold, never both
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      phase_r <= PH_IDLE;
      o_phase_sample <= 1'b0;
      o_phase_hold <= 1'b0;
    end else begin
      case (phase_r)
        PH_IDLE: begin
          phase_r <= PH_SAMPLE;
          o_phase_sample <= 1'b1;
          o_phase_hold <= 1'b0;
        end
        PH_SAMPLE: begin
          phase_r <= PH_GAP1;
          o_phase_sample <= 1'b0;
          o_phase_hold <= 1'b0;
        end
        PH_GAP1: begin
          phase_r <= PH_HOLD;
          o_phase_sample <= 1'b0;
          o_phase_hold <= 1'b1;
        end
        PH_HOLD: begin
          phase_r <= PH_IDLE;
          o_phase_sample <= 1'b0;
          o_phase_hold <= 1'b0;
        end
        default: begin
          phase_r <= PH_IDLE;
          o_phase_sample <= 1'b0;
          o_phase_hold <= 1'b0;
        end
      endcase
    end
  end

  // Valid tracks latency from reset and power-down release
  always @(posedge i_core_clk) begin
    if (i_srst || i_pwrdn) begin
      vld_pipe_r <= {LATENCY{1'b0}};
    end else begin
      vld_pipe_r <= {vld_pipe_r[LATENCY-2:0], 1'b1};
    end
  end

  // Word register; one update per clock keeps samples in order
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_sample <= {DATA_W{1'b0}};
      o_sample_valid <= 1'b0;
    end else begin
      o_sample <= corr_r;
      o_sample_valid <= vld_pipe_r[LATENCY-2] && !i_pwrdn;
    end
  end

  // is trusted: a toggling enable would chop words mid-cycle
  assign out_on = !i_oe_n && !i_pwrdn;
  assign o_sample_oe = {DATA_W{out_on}};

  // Overflow is sticky until reset, so lost words are never hidden
  always @(posedge i_core_clk) begin
    if (i_srst) begin
      overflow_r <= 1'b0;
    end else if (o_sample_valid && !fifo_in_ready) begin
      overflow_r <= 1'b1;
    end
  end
  assign o_overflow = overflow_r;

  sample_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_in_valid(o_sample_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(o_sample),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(o_rd_data)
  );
endmodule // adc_output_port

// [bench/port_chk.sv]
// Assertions on the pins of the converter output port.
// Assumes one clock and a synchronous active-high reset.
module port_chk #(parameter DATA_W = 10, parameter STAGES = 9) (
  input wire i_core_clk, i_srst, i_oe_n, i_pwrdn, i_rd_ready,
  input wire [2*STAGES-1:0] i_stage_code,
  input wire o_rd_valid, o_sample_valid, o_phase_sample, o_phase_hold, o_overflow,
  input wire [DATA_W-1:0] o_rd_data, o_sample, o_sample_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence quiet4; !o_sample_valid [*4]; endsequence
  sequence revive; quiet4 ##[1:2] o_sample_valid; endsequence
  pd_float_a: assert property (i_pwrdn |-> o_sample_oe == '0) else $error("pd drives");
  pd_novalid_a: assert property (i_pwrdn |=> !o_sample_valid) else $error("pd valid");
  pd_latency_a: assert property ($fell(i_pwrdn) |-> revive) else $error("pd wake");
  oe_float_a: assert property (i_oe_n |-> o_sample_oe == '0) else $error("oe float");
  oe_drive_a: assert property (!i_oe_n && !i_pwrdn |-> o_sample_oe == '1) else $error("oe");
  valid_run_a: assert property (o_sample_valid && !i_pwrdn |=> o_sample_valid) else $error("gap");
  phase_gap_a: assert property (!(o_phase_sample && o_phase_hold)) else $error("overlap");
  phase_seq_a: assert property (o_phase_sample && !i_pwrdn ##1 !i_pwrdn |-> !o_phase_hold ##1
    o_phase_hold) else $error("phase order");
  rd_hold_a: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
    else $error("fifo hold");
endmodule // port_chk
bind adc_output_port port_chk #(.DATA_W(DATA_W), .STAGES(STAGES)) u_port_chk (.*);

// [bench/capture_host.sv]
// Capture logic model: latches driven words and paces the FIFO drain.
// Assumes one clock; the bench steers the stall and float requests.
module capture_host (
  input wire i_core_clk,
  input wire i_stall,
  input wire i_float,
  input wire [9:0] i_sample,
  input wire [9:0] i_sample_oe,
  input wire i_sample_valid,
  output logic o_rd_ready,
  output logic o_oe_n,
  output logic [9:0] o_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] bus;
  initial begin
    o_rd_ready = 1'b1;
    o_oe_n = 1'b0;
    o_word = 10'h000;
  end
  // Floating lines read as the inverse of their last value, never a stale copy
  assign bus = (i_sample_oe & i_sample) | (~i_sample_oe & ~o_word);
  always @(posedge i_core_clk) begin
    o_rd_ready <= !i_stall;
    o_oe_n <= i_float;
    if (i_sample_valid)
      o_word <= bus;
  end
endmodule // capture_host

// [bench/testbench.sv]
// Self-checking bench for the converter output port and its capture partner.
// Assumes the default nine-stage pipeline and an eight-word FIFO.
`include "adc_port_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 0, i_srst = 1, i_pwrdn = 0, stall = 0, flt = 0;
  logic [17:0] i_stage_code = '0;
  logic i_oe_n, i_rd_ready, o_rd_valid, o_sample_valid, o_overflow;
  logic [9:0] o_rd_data, o_sample, o_sample_oe, host_word;
  int mismatches = 0, checks_done = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  adc_output_port u_adc_output_port (.i_core_clk(i_core_clk), .i_srst(i_srst),
    .i_stage_code(i_stage_code), .i_oe_n(i_oe_n), .i_pwrdn(i_pwrdn), .i_rd_ready(i_rd_ready),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_sample(o_sample),
    .o_sample_oe(o_sample_oe), .o_sample_valid(o_sample_valid), .o_phase_sample(),
    .o_phase_hold(), .o_overflow(o_overflow));
  capture_host u_capture_host (.i_core_clk(i_core_clk), .i_stall(stall), .i_float(flt),
    .i_sample(o_sample), .i_sample_oe(o_sample_oe), .i_sample_valid(o_sample_valid),
    .o_rd_ready(i_rd_ready), .o_oe_n(i_oe_n), .o_word(host_word));
  // Redundant sum of weighted stage decisions, re-centred and clamped
  function automatic logic [9:0] exp_code(logic [17:0] c);
    int s;
    s = 0;
    for (int k = 0; k < 9; k++) s += int'(c[2*k +: 2]) << k;
    s = s - 766 + 512;
    return (s < 0) ? 10'h000 : ((s > 1023) ? 10'h3FF : 10'(s));
  endfunction
  function automatic logic [9:0] exp_oe(logic n, logic pd);
    return (n | pd) ? 10'h000 : 10'h3FF;
  endfunction
  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(logic [9:0] g, logic [9:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  // Bounded wait: sel 0 for a valid word, sel 1 for an empty FIFO
  task automatic wait_for(bit sel, int lim);
    int k;
    k = 0;
    while ((sel ? o_rd_valid !== 1'b0 : o_sample_valid !== 1'b1) && k < lim) begin
      cyc(1);
      #1;
      k++;
    end
    if (sel ? o_rd_valid !== 1'b0 : o_sample_valid !== 1'b1) begin
      mismatches++;
      $display("Error %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic release_chk;
    repeat (4) begin
      cyc(1);
      #1 chk(o_sample_valid, 1'b0);
    end
    wait_for(1'b0, 3);
  endtask
  initial begin
    void'($urandom(49));
    cyc(12);
    i_srst <= 1'b0;
    release_chk();
    i_stage_code <= '1;
    cyc(14);
    #1 chk(o_sample, `ADC_CODE_MAX);
    chk(o_rd_data, `ADC_CODE_MAX);
    chk(host_word, `ADC_CODE_MAX);
    cyc(1);
    i_stage_code <= '0;
    cyc(14);
    #1 chk(o_sample, `ADC_CODE_MIN);
    chk(o_rd_data, `ADC_CODE_MIN);
    i_stage_code <= 18'h22AAA;
    cyc(14);
    #1 chk(o_sample, `ADC_MIDSCALE);
    repeat (4) begin
      i_stage_code <= 18'($urandom);
      cyc(12);
      #1 chk(o_sample, exp_code(i_stage_code));
    end
    cyc(1);
    stall <= 1'b1;
    repeat (40) begin
      cyc(1);
      i_stage_code <= 18'($urandom);
    end
    #1 chk(o_overflow, 1'b1);
    chk(o_rd_valid, 1'b1);
    cyc(1);
    flt <= 1'b1;
    cyc(2);
    #1 chk(o_sample_oe, exp_oe(1'b1, 1'b0));
    cyc(1);
    flt <= 1'b0;
    cyc(2);
    #1 chk(o_sample_oe, exp_oe(1'b0, 1'b0));
    cyc(1);
    stall <= 1'b0;
    i_pwrdn <= 1'b1;
    cyc(2);
    #1 chk(o_sample_oe, exp_oe(1'b0, 1'b1));
    chk(o_sample_valid, 1'b0);
    wait_for(1'b1, 20);
    cyc(1);
    i_pwrdn <= 1'b0;
    release_chk();
    cyc(1);
    i_srst <= 1'b1;
    cyc(1);
    i_srst <= 1'b0;
    #1 chk(o_overflow, 1'b0);
    release_chk();
    give_verdict();
  end
endmodule // testbench
